// ==== pkg/ctb_pkg.sv ====
// Package with register map, field layout and encodings of the transmit buffer block.
package ctb_pkg;
  localparam int NUM_BUF = 3;
  localparam logic [7:0] BUF_STRIDE = 8'h10;
  localparam logic [7:0] OFS_IDH = 8'h00;
  localparam logic [7:0] OFS_IDL = 8'h02;
  localparam logic [7:0] OFS_DATA0 = 8'h04;
  localparam logic [7:0] OFS_DATA1 = 8'h06;
  localparam logic [7:0] OFS_DATA2 = 8'h08;
  localparam logic [7:0] OFS_DATA3 = 8'h0a;
  localparam logic [7:0] OFS_FMT = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h0e;
  localparam logic [7:0] OFS_F1_CODE_IDH = 8'h64;
  localparam logic [7:0] OFS_F1_CODE_IDL = 8'h66;
  localparam logic [7:0] OFS_F1_CODE_PAY = 8'h68;
  localparam logic [7:0] OFS_F2_MASK_IDH = 8'h6a;
  localparam logic [7:0] OFS_F2_MASK_IDL = 8'h6c;
  localparam logic [7:0] OFS_F2_MASK_PAY = 8'h6e;
  localparam logic [7:0] OFS_F2_CODE_IDH = 8'h70;
  localparam logic [7:0] OFS_F2_CODE_IDL = 8'h72;
  localparam logic [7:0] OFS_F2_CODE_PAY = 8'h74;
  localparam logic [7:0] OFS_ARB_LOSS = 8'h76;
  localparam logic [7:0] OFS_FAULT = 8'h78;
  localparam logic [7:0] OFS_FRAME_POS = 8'h7a;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h80;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h82;
  localparam logic [7:0] OFS_IRQ_EN = 8'h84;
  localparam logic [7:0] OFS_TX_LEVEL = 8'h86;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int FMT_RTR_BIT = 5;
  localparam int FMT_IDE_BIT = 4;
  localparam logic [15:0] IDL_MASK = 16'hfff8;
  localparam logic [15:0] FMT_MASK = 16'h003f;
  localparam logic [15:0] ARB_MASK = 16'h1f3f;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam int IRQ_MSG_BIT = 3;
  typedef enum logic [1:0] {
    CTB_IDLE = 2'b00,
    CTB_SEND = 2'b01
  } ctb_state_e;
endpackage

// ==== logic/ctb_can_tx_buffers.sv ====
// Three transmit holding buffers with priority arbiter, capture words and Wishbone slave.
`timescale 1ns/1ps
// Overview of operation
// R1 - Three transmit buffers; arbiter sends the pending one of highest priority.
// R2 - After any abort or arbitration loss, reselect among still pending buffers.
// R3 - Software loads a full message, then sets that buffer's send request flag.
// R4 - Send request flag stays set while pending; software leaves buffer untouched.
// R5 - Successful send clears send request and raises per-buffer complete interrupt.
// R6 - Extra interrupt when buffers empty or occupancy falls below chosen level.
// R7 - Cancel flag removes pending message at next arbitration loss, stays set meanwhile.
// R8 - Cancel flag clears on arbitration win with interrupt, or removal without it.
// R9 - Send request flag is released together with the cancel flag.
// R10 - Identifier in two words; low word holds bits 12..0 in 15:3.
// R11 - Data bytes two per word, first byte in low half, from offset 04h.
// R12 - Format word: remote bit 5, extended bit 4, length 3:0, sent unchanged.
// R13 - Control word: request bit 0, cancel bit 1; writing one starts request.
// R14 - Second and third buffers share layout, differing only in base offset.
// R15 - Fault capture: code 15:13, field 12:8, tx/rx mode 7:6, position 5:0.
// R16 - Frame position: stuff 15, rx/tx bit 14:13, field, modes and position.
// R17 - Arbitration loss capture: field 12:8, position 5:0, rest reserved.
// R18 - Lowest identifier wins; standard beats extended with equal leading bits (standard remote ties extended data with low 18 id bits zero).
// R19 - Filter code and mask cover identifier, flags and first two data bytes.
module ctb_can_tx_buffers (
  input wire logic SYS_CLK, // System clock, 100 MHz.
  input wire logic SYS_RST, // Asynchronous reset, active high.
  input wire logic [7:0] WB_ADR_I, // Byte address.
  input wire logic [15:0] WB_DAT_I, // Write data.
  output logic [15:0] WB_DAT_O, // Read data.
  input wire logic [1:0] WB_SEL_I, // Byte enables.
  input wire logic WB_WE_I, // Write enable.
  input wire logic WB_CYC_I, // Cycle.
  input wire logic WB_STB_I, // Strobe.
  output logic WB_ACK_O, // Acknowledge.
  output logic TX_VALID, // Message offered to the bit engine.
  output logic [1:0] TX_BUF, // Index of the offered buffer.
  output logic [28:0] TX_IDENT, // Offered identifier.
  output logic [63:0] TX_DATA, // Offered data, first byte in 63:56.
  output logic [5:0] TX_FORMAT, // Offered remote, extended and length.
  input wire logic TX_START, // Engine began sending the offered message.
  input wire logic TX_DONE, // Message sent completely.
  input wire logic TX_ARB_LOST, // Arbitration lost by the message being sent.
  input wire logic TX_ABORTED, // Frame ended by an error.
  input wire logic [15:0] ARB_CAPTURE, // Field and position of lost arbitration.
  input wire logic [15:0] FAULT_WORD, // Error code, field, modes and position.
  input wire logic FAULT_STB, // Loads FAULT_WORD into the capture.
  input wire logic [15:0] FRAME_POS, // Live frame position word.
  output logic [47:0] FILT1_CODE, // Filter 1 code for the receive path.
  output logic [47:0] FILT2_CODE, // Filter 2 code.
  output logic [47:0] FILT2_MASK, // Filter 2 mask.
  output logic IRQ // Level interrupt.
);
  import ctb_pkg::*;

  logic [15:0] idh_r [NUM_BUF];
  logic [15:0] idl_r [NUM_BUF];
  logic [15:0] dat_r [NUM_BUF][4];
  logic [15:0] fmt_r [NUM_BUF];
  logic [NUM_BUF-1:0] req_r;
  logic [NUM_BUF-1:0] abt_r;
  logic [15:0] filt_r [9];
  logic [15:0] arb_r;
  logic [15:0] fault_r;
  logic [15:0] fpos_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_en_r;
  logic [1:0] level_r;
  ctb_state_e state_r;
  logic [1:0] cur_r;
  logic won_r;
  logic ack_nxt;
  logic wr;
  logic [1:0] bsel;
  logic [7:0] boff;
  logic [15:0] rd_nxt;
  logic [1:0] best;
  logic best_ok;
  logic [NUM_BUF-1:0] done_set;
  logic [NUM_BUF-1:0] drop;
  logic [1:0] occ;

  // Arbitration key: bus order less the extended IDE bit; standard frames carry a dominant bit after 11 id bits and the remote bit.
  function automatic logic [30:0] prio_key(input logic [15:0] h, input logic [15:0] l,
                                           input logic [15:0] f);
    if (f[FMT_IDE_BIT]) begin
      prio_key = {h[15:5], 1'b1, h[4:0], l[15:3], f[FMT_RTR_BIT]}; // [R18]
    end else begin
      prio_key = {h[15:5], f[FMT_RTR_BIT], 1'b0, 18'h00000}; // [R18]
    end
  endfunction

  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [1:0] sel);
    byte_merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
  assign ack_nxt = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign bsel = WB_ADR_I[5:4]; // [R14]
  assign boff = {4'h0, WB_ADR_I[3:0]};

  // Priority selection over every buffer still pending, including the one being sent.
  always_comb begin
    logic [30:0] bk;
    bk = '1;
    best = 2'd0;
    best_ok = 1'b0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (req_r[i] && (!best_ok || prio_key(idh_r[i], idl_r[i], fmt_r[i]) < bk)) begin // [R1]
        bk = prio_key(idh_r[i], idl_r[i], fmt_r[i]);
        best = 2'(i);
        best_ok = 1'b1;
      end
    end
  end

  always_comb begin
    done_set = '0;
    drop = '0;
    if (state_r == CTB_SEND && TX_DONE) begin
      done_set[cur_r] = 1'b1; // [R5]
    end
    if (state_r == CTB_SEND && TX_ARB_LOST && abt_r[cur_r]) begin
      drop[cur_r] = 1'b1; // [R7]
    end
  end

  // Occupancy after this cycle's completions and removals, so the last send reports empty.
  assign occ = 2'(req_r[0] && !done_set[0] && !drop[0]) + 2'(req_r[1] && !done_set[1] && !drop[1])
             + 2'(req_r[2] && !done_set[2] && !drop[2]); // [R6]

  // Bit engine handshake; any loss or abort returns to idle so selection reruns.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= CTB_IDLE;
      cur_r <= 2'd0;
      won_r <= 1'b0;
    end else begin
      case (state_r)
        CTB_IDLE: begin
          won_r <= 1'b0;
          cur_r <= best;
          if (best_ok && TX_START) begin
            state_r <= CTB_SEND;
          end
        end
        CTB_SEND: begin
          if (TX_ARB_LOST && !won_r) begin
            // Empty branch: won_r is never set, so a loss counts at any point of the frame.
          end
          if (TX_DONE || TX_ARB_LOST || TX_ABORTED) begin
            state_r <= CTB_IDLE; // [R2]
          end
        end
        default: state_r <= CTB_IDLE;
      endcase
    end
  end

  // Offered message follows the selection while idle; frozen during a frame.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_VALID <= 1'b0;
      TX_BUF <= 2'd0;
      TX_IDENT <= '0;
      TX_DATA <= '0;
      TX_FORMAT <= '0;
    end else if (state_r == CTB_IDLE && !TX_START) begin
      TX_VALID <= best_ok && !(done_set != '0) && (drop == '0);
      TX_BUF <= best;
      TX_IDENT <= {idh_r[best], idl_r[best][15:3]}; // [R10]
      TX_DATA <= {dat_r[best][0][7:0], dat_r[best][0][15:8], dat_r[best][1][7:0],
                  dat_r[best][1][15:8], dat_r[best][2][7:0], dat_r[best][2][15:8],
                  dat_r[best][3][7:0], dat_r[best][3][15:8]}; // [R11]
      TX_FORMAT <= fmt_r[best][5:0]; // [R12]
    end else begin
      // Withdraw the offer on the take itself, so it is gone one cycle after the start.
      TX_VALID <= 1'b0;
    end
  end

  // Message words; writes to a buffer whose request is set are ignored.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        idh_r[i] <= RESET_WORD;
        idl_r[i] <= RESET_WORD;
        fmt_r[i] <= RESET_WORD;
        for (int j = 0; j < 4; j++) begin
          dat_r[i][j] <= RESET_WORD;
        end
      end
    end else if (wr && WB_ADR_I < 8'h30 && !req_r[bsel]) begin // [R4]
      case (boff)
        OFS_IDH: idh_r[bsel] <= byte_merge(idh_r[bsel], WB_DAT_I, WB_SEL_I);
        OFS_IDL: idl_r[bsel] <= byte_merge(idl_r[bsel], WB_DAT_I, WB_SEL_I) & IDL_MASK; // [R10]
        OFS_DATA0: dat_r[bsel][0] <= byte_merge(dat_r[bsel][0], WB_DAT_I, WB_SEL_I);
        OFS_DATA1: dat_r[bsel][1] <= byte_merge(dat_r[bsel][1], WB_DAT_I, WB_SEL_I);
        OFS_DATA2: dat_r[bsel][2] <= byte_merge(dat_r[bsel][2], WB_DAT_I, WB_SEL_I);
        OFS_DATA3: dat_r[bsel][3] <= byte_merge(dat_r[bsel][3], WB_DAT_I, WB_SEL_I);
        OFS_FMT: fmt_r[bsel] <= byte_merge(fmt_r[bsel], WB_DAT_I, WB_SEL_I) & FMT_MASK; // [R12]
        default: ;
      endcase
    end
  end

  // Request and cancel flags; hardware clears them, software may only set them.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      req_r <= '0;
      abt_r <= '0;
    end else begin
      for (int i = 0; i < NUM_BUF; i++) begin
        if (wr && WB_ADR_I == 8'(i * BUF_STRIDE) + OFS_CTRL && WB_SEL_I[0]) begin
          if (WB_DAT_I[CTRL_REQ_BIT]) begin
            req_r[2'(i)] <= 1'b1; // [R3] [R13]
          end
          if (WB_DAT_I[CTRL_ABORT_BIT] && req_r[i]) begin
            abt_r[2'(i)] <= 1'b1; // [R7]
          end
        end
        if (done_set[i] || drop[i]) begin
          req_r[2'(i)] <= 1'b0; // [R5] [R9]
          abt_r[2'(i)] <= 1'b0; // [R8]
        end
      end
    end
  end

  // Filter words are held here and handed to the receive path.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int k = 0; k < 9; k++) begin
        filt_r[k] <= RESET_WORD;
      end
    end else if (wr && WB_ADR_I >= OFS_F1_CODE_IDH && WB_ADR_I <= OFS_F2_CODE_PAY) begin
      filt_r[4'((WB_ADR_I - OFS_F1_CODE_IDH) >> 1)] <=
        byte_merge(filt_r[4'((WB_ADR_I - OFS_F1_CODE_IDH) >> 1)], WB_DAT_I, WB_SEL_I); // [R19]
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FILT1_CODE <= '0;
      FILT2_MASK <= '0;
      FILT2_CODE <= '0;
    end else begin
      FILT1_CODE <= {filt_r[0], filt_r[1], filt_r[2]}; // [R19]
      FILT2_MASK <= {filt_r[3], filt_r[4], filt_r[5]};
      FILT2_CODE <= {filt_r[6], filt_r[7], filt_r[8]};
    end
  end

  // Capture words: arbitration loss and fault latch on their event, position is live.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      arb_r <= RESET_WORD;
      fault_r <= RESET_WORD;
      fpos_r <= RESET_WORD;
    end else begin
      if (state_r == CTB_SEND && TX_ARB_LOST) begin
        arb_r <= ARB_CAPTURE & ARB_MASK; // [R17]
      end
      if (FAULT_STB) begin
        fault_r <= FAULT_WORD; // [R15]
      end
      fpos_r <= FRAME_POS; // [R16]
    end
  end

  // Interrupt status; a new event wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat_r <= IRQ_RESET;
      irq_en_r <= IRQ_RESET;
      level_r <= LEVEL_RESET;
    end else begin
      logic [3:0] clr;
      logic [3:0] set;
      clr = (wr && WB_ADR_I == OFS_IRQ_CLR && WB_SEL_I[0]) ? WB_DAT_I[3:0] : 4'h0;
      set = {1'b0, done_set}; // [R5]
      if ((occ == 2'd0 || occ < level_r) && (done_set != '0 || drop != '0)) begin
        set[IRQ_MSG_BIT] = 1'b1; // [R6]
      end
      irq_stat_r <= (irq_stat_r & ~clr) | set;
      if (wr && WB_ADR_I == OFS_IRQ_EN && WB_SEL_I[0]) begin
        irq_en_r <= WB_DAT_I[3:0];
      end
      if (wr && WB_ADR_I == OFS_TX_LEVEL && WB_SEL_I[0]) begin
        level_r <= WB_DAT_I[1:0]; // [R6]
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_en_r);
    end
  end

  always_comb begin
    rd_nxt = 16'h0000;
    if (WB_ADR_I < 8'h30 && bsel != 2'd3) begin
      case (boff)
        OFS_IDH: rd_nxt = idh_r[bsel];
        OFS_IDL: rd_nxt = idl_r[bsel];
        OFS_DATA0: rd_nxt = dat_r[bsel][0];
        OFS_DATA1: rd_nxt = dat_r[bsel][1];
        OFS_DATA2: rd_nxt = dat_r[bsel][2];
        OFS_DATA3: rd_nxt = dat_r[bsel][3];
        OFS_FMT: rd_nxt = fmt_r[bsel];
        OFS_CTRL: rd_nxt = {14'h0000, abt_r[bsel], req_r[bsel]}; // [R4] [R13]
        default: rd_nxt = 16'h0000;
      endcase
    end else if (WB_ADR_I >= OFS_F1_CODE_IDH && WB_ADR_I <= OFS_F2_CODE_PAY && !WB_ADR_I[0]) begin
      rd_nxt = filt_r[4'((WB_ADR_I - OFS_F1_CODE_IDH) >> 1)];
    end else begin
      case (WB_ADR_I)
        OFS_ARB_LOSS: rd_nxt = arb_r;
        OFS_FAULT: rd_nxt = fault_r;
        OFS_FRAME_POS: rd_nxt = fpos_r;
        OFS_IRQ_STAT: rd_nxt = {12'h000, irq_stat_r};
        OFS_IRQ_EN: rd_nxt = {12'h000, irq_en_r};
        OFS_TX_LEVEL: rd_nxt = {14'h0000, level_r};
        default: rd_nxt = 16'h0000;
      endcase
    end
  end

  // One wait-free cycle: ack the edge after the request, drop it the next.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 16'h0000;
    end else begin
      WB_ACK_O <= ack_nxt;
      WB_DAT_O <= ack_nxt ? rd_nxt : 16'h0000;
    end
  end
endmodule

// ==== bench/ctb_can_tx_buffers_sva.sv ====
// Checker for bus answer timing, engine handshake and read-back field layout.
`timescale 1ns/1ps
module ctb_can_tx_buffers_chk (
  input wire logic SYS_CLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic [7:0] WB_ADR_I, // Address.
  input wire logic WB_WE_I, // Write enable.
  input wire logic WB_CYC_I, // Cycle.
  input wire logic WB_STB_I, // Strobe.
  input wire logic WB_ACK_O, // Acknowledge.
  input wire logic [15:0] WB_DAT_O, // Read data.
  input wire logic TX_VALID, // Offer.
  input wire logic TX_START // Engine take.
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  wire logic rd = WB_ACK_O && !WB_WE_I;
  wire logic bufw = WB_ADR_I < 8'h30;
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered in one cycle");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 16'h0000)
    else $error("read data outside acknowledge");
  offer_take_a: assert property (TX_VALID && TX_START |=> !TX_VALID)
    else $error("offer kept after engine took it");
  offer_hold_a: assert property (TX_VALID && !TX_START |=> TX_VALID)
    else $error("offer withdrawn without engine event");
  arb_read_a: assert property (rd && WB_ADR_I == 8'h76 |-> (WB_DAT_O & 16'he0c0) == 16'h0)
    else $error("reserved loss capture bits set");
  idl_read_a: assert property (rd && bufw && WB_ADR_I[3:0] == 4'h2 |-> WB_DAT_O[2:0] == 3'h0)
    else $error("reserved identifier bits set");
  fmt_read_a: assert property (rd && bufw && WB_ADR_I[3:0] == 4'hc |-> WB_DAT_O[15:6] == 10'h0)
    else $error("reserved format bits set");
endmodule
bind ctb_can_tx_buffers ctb_can_tx_buffers_chk ctb_can_tx_buffers_chk_inst (.SYS_CLK, .SYS_RST,
  .WB_ADR_I, .WB_WE_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .WB_DAT_O, .TX_VALID, .TX_START);

// ==== bench/ctb_engine_model.sv ====
// Behavioural bit engine standing on the bus side of the transmit buffers.
`timescale 1ns/1ps
module ctb_engine_model (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset, active high.
  input wire logic en, // Allows new frames.
  input wire logic lose, // Frames lose arbitration.
  input wire logic [4:0] lat, // Frame length in cycles, less one.
  input wire logic tx_valid, // Offer.
  input wire logic [1:0] tx_buf, // Offered buffer.
  input wire logic [28:0] tx_ident, // Offered identifier.
  input wire logic [63:0] tx_data, // Offered data.
  input wire logic [5:0] tx_format, // Offered format.
  output logic tx_start, // Frame started.
  output logic tx_done, // Frame sent.
  output logic tx_arb_lost, // Arbitration lost.
  output logic [15:0] arb_capture, // Loss position.
  output logic [1:0] got_buf, // Last buffer taken.
  output logic [98:0] got_msg, // Last ident, data, format.
  output logic [7:0] got_cnt // Frames taken.
);
  logic busy_r;
  logic [4:0] cnt_r;
  // All ones, so the capture must mask its reserved bits itself.
  assign arb_capture = 16'hffff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
      tx_start <= 1'b0;
      tx_done <= 1'b0;
      tx_arb_lost <= 1'b0;
      got_buf <= 2'h0;
      got_msg <= '0;
      got_cnt <= 8'h00;
    end else begin
      tx_start <= 1'b0;
      tx_done <= 1'b0;
      tx_arb_lost <= 1'b0;
      if (!busy_r && en && tx_valid) begin
        tx_start <= 1'b1;
        busy_r <= 1'b1;
        cnt_r <= lat;
        got_buf <= tx_buf;
        got_msg <= {tx_ident, tx_data, tx_format};
        got_cnt <= got_cnt + 8'h01;
      end else if (busy_r && cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        tx_arb_lost <= lose;
        tx_done <= !lose;
      end
    end
  end
endmodule

// ==== bench/ctb_can_tx_buffers_tb.sv ====
// Self-checking bench for the transmit buffers with a modelled bit engine.
`timescale 1ns/1ps
module ctb_can_tx_buffers_tb;
  import ctb_pkg::*;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} ctb_row_s;
  localparam ctb_row_s ROWS [11] = '{'{8'h00, 16'hffff, 16'hffff}, '{8'h02, 16'hffff, 16'hfff8},
    '{8'h04, 16'ha55a, 16'ha55a}, '{8'h0c, 16'hffff, 16'h003f}, '{8'h0e, 16'h0000, 16'h0000},
    '{8'h1c, 16'h00ff, 16'h003f}, '{8'h22, 16'h1234, 16'h1230}, '{8'h64, 16'hbeef, 16'hbeef},
    '{8'h74, 16'h0ff0, 16'h0ff0}, '{8'h76, 16'h1234, 16'h0000}, '{8'h90, 16'h1234, 16'h0000}};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [15:0] wdat = 16'h0000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic en = 1'b0;
  logic lose = 1'b0;
  logic [4:0] lat = 5'h00;
  logic fault_stb = 1'b0;
  logic [15:0] fault_word = 16'h0000;
  logic [15:0] rdat, dat_o, arb_cap;
  logic ack, tx_valid, tx_start, tx_done, tx_lost, irq;
  logic [1:0] tx_buf, got_buf;
  logic [28:0] tx_ident;
  logic [63:0] tx_data;
  logic [5:0] tx_format;
  logic [47:0] filt1;
  logic [98:0] got_msg;
  logic [7:0] got_cnt;
  int fails = 0;
  int num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  ctb_can_tx_buffers ctb_can_tx_buffers_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_SEL_I(2'h3), .WB_WE_I(we),
    .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_ACK_O(ack), .TX_VALID(tx_valid), .TX_BUF(tx_buf),
    .TX_IDENT(tx_ident), .TX_DATA(tx_data), .TX_FORMAT(tx_format), .TX_START(tx_start),
    .TX_DONE(tx_done), .TX_ARB_LOST(tx_lost), .TX_ABORTED(1'b0), .ARB_CAPTURE(arb_cap),
    .FAULT_WORD(fault_word), .FAULT_STB(fault_stb), .FRAME_POS(16'he2a5),
    .FILT1_CODE(filt1), .FILT2_CODE(), .FILT2_MASK(), .IRQ(irq));
  ctb_engine_model ctb_engine_model_inst (.clk(sys_clk), .rst(sys_rst), .en(en), .lose(lose),
    .lat(lat), .tx_valid(tx_valid), .tx_buf(tx_buf), .tx_ident(tx_ident), .tx_data(tx_data),
    .tx_format(tx_format), .tx_start(tx_start), .tx_done(tx_done), .tx_arb_lost(tx_lost),
    .arb_capture(arb_cap), .got_buf(got_buf), .got_msg(got_msg), .got_cnt(got_cnt));
  task automatic check(input logic [98:0] got, input logic [98:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; the request stands until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    check(n < 50, 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    check(rdat, e);
  endtask
  task automatic wait_sent(input int want, input logic [1:0] b);
    int n;
    n = 0;
    while (got_cnt !== 8'(want) && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    check(got_buf, b);
  endtask
  task automatic wait_clear(input logic [7:0] a);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 16'h0000);
      n++;
    end while (rdat !== 16'h0000 && n < 100);
    check(rdat, 16'h0000);
  endtask
  task automatic stop_test();
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h80, 16'h0000);
    foreach (ROWS[i]) begin
      wb(1'b1, ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].e);
    end
    check(filt1[47:32], 16'hbeef);
    lat <= 5'd20;
    en <= 1'b1;
    wb(1'b1, 8'h10, 16'h1234);
    wb(1'b1, 8'h12, 16'h5678);
    for (int k = 0; k < 4; k++) wb(1'b1, 8'h14 + 8'(2 * k), 16'h2211 + 16'(k) * 16'h2222);
    wb(1'b1, 8'h1c, 16'h000a);
    wb(1'b1, 8'h1e, 16'h0001);
    rd(8'h1e, 16'h0001);
    wb(1'b1, 8'h14, 16'hdead);
    rd(8'h14, 16'h2211);
    wait_sent(1, 2'd1);
    check(got_msg, {16'h1234, 13'h0acf, 64'h1122334455667788, 6'h0a});
    wait_clear(8'h1e);
    rd(8'h80, 16'h000a);
    check(irq, 1'b0);
    wb(1'b1, 8'h84, 16'h000f);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b1);
    wb(1'b1, 8'h82, 16'h000f);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0);
    en <= 1'b0;
    lat <= 5'd0;
    for (int b = 0; b < 3; b++) begin
      wb(1'b1, 8'(16 * b), (b == 0) ? 16'h0200 : 16'h0100);
      wb(1'b1, 8'(16 * b + 2), 16'h0000);
      wb(1'b1, 8'(16 * b + 12), (b == 2) ? 16'h0000 : 16'h0010);
      wb(1'b1, 8'(16 * b + 14), 16'h0001);
    end
    wb(1'b1, 8'h2e, 16'h0003);
    en <= 1'b1;
    wait_sent(2, 2'd2);
    wait_sent(3, 2'd1);
    wait_sent(4, 2'd0);
    wait_clear(8'h0e);
    rd(8'h2e, 16'h0000);
    rd(8'h80, 16'h000f);
    wb(1'b1, 8'h82, 16'h000f);
    en <= 1'b0;
    lose <= 1'b1;
    lat <= 5'd20;
    wb(1'b1, 8'h86, 16'h0002);
    wb(1'b1, 8'h00, 16'h0300);
    wb(1'b1, 8'h20, 16'h0400);
    wb(1'b1, 8'h0e, 16'h0001);
    wb(1'b1, 8'h2e, 16'h0001);
    wb(1'b1, 8'h0e, 16'h0002);
    rd(8'h0e, 16'h0003);
    en <= 1'b1;
    wait_sent(5, 2'd0);
    wait_sent(6, 2'd2);
    lose <= 1'b0;
    rd(8'h80, 16'h0008);
    rd(8'h0e, 16'h0000);
    rd(8'h76, 16'h1f3f);
    wait_clear(8'h2e);
    rd(8'h80, 16'h000c);
    fault_word <= 16'hb5c7;
    fault_stb <= 1'b1;
    @(posedge sys_clk);
    fault_stb <= 1'b0;
    rd(8'h78, 16'hb5c7);
    rd(8'h7a, 16'he2a5);
    en <= 1'b0;
    wb(1'b1, 8'h0e, 16'h0001);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h0e, 16'h0000);
    check(filt1, 48'h0);
    stop_test();
  end
endmodule
